// ==== hw/tor_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the output router.
// Assumes: 100 MHz reference clock, APB with 32-bit data and byte addresses.
// Notes: Definitions only.
`ifndef TOR_PARAMS_SVH
`define TOR_PARAMS_SVH

// Register byte offsets
`define TOR_OFS_STROBE_RISE 8'h00
`define TOR_OFS_STROBE_FALL 8'h04
`define TOR_OFS_EXPO_DELAY 8'h08
`define TOR_OFS_EXPO_TIME 8'h0C
`define TOR_OFS_PORT_BASE 8'h10
`define TOR_OFS_STATUS 8'h40

// Port configuration field layout
`define TOR_CFG_W 12
`define TOR_CFG_PIN_BIT 16
`define TOR_CFG_RESET 12'h000

// Status layout: ready bits, exposure, strobe, then pin levels
`define TOR_STS_READY_LSB 0
`define TOR_STS_EXPO_BIT 3
`define TOR_STS_STROBE_BIT 4
`define TOR_STS_PIN_LSB 8

// Delay register width and reset values
`define TOR_DLY_W 16
`define TOR_DLY_RESET 16'h0000

// Timing: clock period, microsecond tick and trigger pulse length
`define TOR_CLK_NS 10
`define TOR_US_NS 1000
`define TOR_US_CYC (`TOR_US_NS / `TOR_CLK_NS)
`define TOR_TRIG_PULSE_NS 5000
`define TOR_TRIG_PULSE_CYC (`TOR_TRIG_PULSE_NS / `TOR_CLK_NS)

`endif

// ==== hw/tor_pkg.sv ====
// Purpose: Types shared by the output router modules.
// Assumes: Field widths match the params header.
// Notes: Source codes above the last member are illegal and route a low level.
package tor_pkg;

    typedef enum logic [3:0] {
        TOR_SRC_MANUAL,
        TOR_SRC_EXPOSURE,
        TOR_SRC_STROBE,
        TOR_SRC_ACQ_TRIG,
        TOR_SRC_FRAME_TRIG,
        TOR_SRC_EOE_TRIG,
        TOR_SRC_ACQ_READY,
        TOR_SRC_FRAME_READY,
        TOR_SRC_EOE_READY,
        TOR_SRC_ENC_TRIG,
        TOR_SRC_PLL_TRIG
    } tor_src_e;

    // Port configuration word, low 12 bits of the port register
    typedef struct packed {
        logic [3:0] extra_source_index;
        logic extra_source_enable;
        logic manual_val;
        logic dir_out;
        logic invert;
        tor_src_e src;
    } tor_port_cfg_s;

    // Trigger event strobes from the trigger manager
    typedef struct packed {
        logic eoe;
        logic frame;
        logic acq;
    } tor_evt_s;

endpackage

// ==== hw/tor_pulse_stretch.sv ====
// Purpose: Stretches a one-cycle event into a fixed-length active-high pulse.
// Assumes: Event is synchronous to the clock.
// Notes: A new event during the pulse restarts the full length.
`timescale 1ns/100ps
module tor_pulse_stretch #(
    parameter int CYC = 500
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic evt,
    output logic pulse
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_ff;

    // Load on event, count down to zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
        end else if (evt) begin
            cnt_ff <= CW'(CYC);
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign pulse = (cnt_ff != '0);
endmodule

// ==== hw/tor_trig_ready.sv ====
// Purpose: Ready tracker of one trigger module.
// Assumes: Rearm comes from the module that finishes the triggered action.
// Notes: Events while not ready are dropped without trace.
`timescale 1ns/100ps
module tor_trig_ready (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic evt,
    input wire logic rearm,
    output logic ready,
    output logic accept
);
    logic ready_ff;

    // Only an event seen while ready is passed on
    assign accept = evt & ready_ff;

    // Idle high, low from acceptance until rearm; acceptance wins a tie
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_ff <= 1'b1;
        end else if (accept) begin
            ready_ff <= 1'b0;
        end else if (rearm) begin
            ready_ff <= 1'b1;
        end
    end

    assign ready = ready_ff;
endmodule

// ==== hw/tor_top.sv ====
// Purpose: Timing signal generation and per-port output source routing.
// Assumes: All inputs synchronous to REF_CLK; APB zero-wait slave.
// Notes: Strobe and exposure share one microsecond counter started by frame events.
//
// Functional notes
// - A port routed to exposure is active exactly while the exposure window runs; here the pin flop makes the port one clock late.
// - The strobe rises after one programmed delay and falls after another, both from the event.
// - Both strobe delays count one-microsecond ticks.
// - Strobe and exposure are separate signals, each delayed from the frame event.
// - Exposure delay and strobe delay are independent, so the strobe may lead exposure.
// - Encoder and frequency multiplier events are selectable sources on any port.
// - Trigger outputs go active on their event and stay active about five microseconds.
// - Each of the three trigger modules has its own ready level as a port source.
// - A ready level idles high, drops on acceptance and rises when a new trigger can be taken.
// - Trigger events that arrive while their module is not ready are discarded.
// - A port may select an extra source by index while its extra enable is set.
// - A port set to output drives its level; set to input its pin is sampled.
// - Per-port inversion applies to the level whatever the source.
// - The manual source drives the level written by software.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "tor_params.svh"
module tor_top #(
    parameter int NPORTS = 4,
    parameter int NEXTRA = 16,
    parameter int US_CYC = `TOR_US_CYC,
    parameter int TRIG_CYC = `TOR_TRIG_PULSE_CYC
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire tor_pkg::tor_evt_s TRIG_EVT,
    input wire logic ACQ_REARM,
    input wire logic EOE_REARM,
    input wire logic ENC_TICK,
    input wire logic PLL_TICK,
    input wire logic [NEXTRA-1:0] EXTRA_SRC,
    output tor_pkg::tor_evt_s TRIG_ACCEPT,
    input wire logic [NPORTS-1:0] PIO_IN,
    output logic [NPORTS-1:0] PIO_OUT,
    output logic [NPORTS-1:0] PIO_OE
);
    import tor_pkg::*;

    localparam int DW = `TOR_DLY_W;
    localparam int PW = $clog2(US_CYC);

    logic [DW-1:0] strobe_rise_delay_ff;
    logic [DW-1:0] strobe_fall_delay_ff;
    logic [DW-1:0] expo_delay_ff;
    logic [DW-1:0] expo_time_ff;
    tor_port_cfg_s cfg_ff [NPORTS];
    logic [NPORTS-1:0] pin_in_ff;
    logic [NPORTS-1:0] pin_out_ff;
    logic [31:0] prdata_ff;

    logic [PW-1:0] pre_ff;
    logic us_tick;
    logic [DW:0] us_cnt_ff;
    logic run_ff;
    logic strobe_ff;
    logic expo_ff;
    logic [DW:0] expo_end;
    logic [DW:0] run_end;
    logic frame_rearm;

    tor_evt_s ready;
    tor_evt_s accept;
    tor_evt_s trig_pulse;
    logic enc_pulse;
    logic pll_pulse;
    logic frame_trig_pulse_out;
    logic frame_trig_ready_out;

    logic setup_ph;
    logic access_ph;
    logic port_hit;
    logic [7:0] port_ofs;
    logic [7:0] port_idx;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // APB phases; slave answers in the first access cycle
    assign setup_ph = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign PREADY = 1'b1;
    assign port_ofs = PADDR - `TOR_OFS_PORT_BASE;
    assign port_idx = {2'b00, port_ofs[7:2]};
    assign port_hit = (PADDR >= `TOR_OFS_PORT_BASE) && (port_ofs[1:0] == 2'b00)
        && (port_idx < 8'(NPORTS));

    // Address decode
    always_comb begin
        addr_ok = 1'b0;
        unique case (PADDR)
            `TOR_OFS_STROBE_RISE,
            `TOR_OFS_STROBE_FALL,
            `TOR_OFS_EXPO_DELAY,
            `TOR_OFS_EXPO_TIME,
            `TOR_OFS_STATUS: addr_ok = 1'b1;
            default: addr_ok = port_hit;
        endcase
    end

    // Unmapped access answers with an error, reads zero, writes nothing
    assign PSLVERR = access_ph & ~addr_ok;

    // Status word: ready levels, exposure, strobe and sampled pins
    always_comb begin
        status_word = '0;
        status_word[`TOR_STS_READY_LSB +: 3] = ready;
        status_word[`TOR_STS_EXPO_BIT] = expo_ff;
        status_word[`TOR_STS_STROBE_BIT] = strobe_ff;
        status_word[`TOR_STS_PIN_LSB +: NPORTS] = pin_in_ff;
    end

    // Read mux
    always_comb begin
        rd_mux = '0;
        if (port_hit) begin
            rd_mux[`TOR_CFG_W-1:0] = cfg_ff[port_idx[$clog2(NPORTS)-1:0]];
            rd_mux[`TOR_CFG_PIN_BIT] = pin_in_ff[port_idx[$clog2(NPORTS)-1:0]];
        end else begin
            unique case (PADDR)
                `TOR_OFS_STROBE_RISE: rd_mux[DW-1:0] = strobe_rise_delay_ff;
                `TOR_OFS_STROBE_FALL: rd_mux[DW-1:0] = strobe_fall_delay_ff;
                `TOR_OFS_EXPO_DELAY: rd_mux[DW-1:0] = expo_delay_ff;
                `TOR_OFS_EXPO_TIME: rd_mux[DW-1:0] = expo_time_ff;
                `TOR_OFS_STATUS: rd_mux = status_word;
                default: rd_mux = '0;
            endcase
        end
    end

    // Read data captured in the setup cycle so it stands from a flop
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_ph && !PWRITE) begin
            prdata_ff <= rd_mux;
        end
    end
    assign PRDATA = prdata_ff;

    // Timing registers, written at the access edge
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strobe_rise_delay_ff <= `TOR_DLY_RESET;
            strobe_fall_delay_ff <= `TOR_DLY_RESET;
            expo_delay_ff <= `TOR_DLY_RESET;
            expo_time_ff <= `TOR_DLY_RESET;
        end else if (access_ph && PWRITE) begin
            unique case (PADDR)
                `TOR_OFS_STROBE_RISE: strobe_rise_delay_ff <= PWDATA[DW-1:0];
                `TOR_OFS_STROBE_FALL: strobe_fall_delay_ff <= PWDATA[DW-1:0];
                `TOR_OFS_EXPO_DELAY: expo_delay_ff <= PWDATA[DW-1:0];
                `TOR_OFS_EXPO_TIME: expo_time_ff <= PWDATA[DW-1:0];
                default: ;
            endcase
        end
    end

    // Port configuration registers
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < NPORTS; i++) begin
                cfg_ff[i] <= tor_port_cfg_s'(`TOR_CFG_RESET);
            end
        end else if (access_ph && PWRITE && port_hit) begin
            cfg_ff[port_idx[$clog2(NPORTS)-1:0]] <= tor_port_cfg_s'(PWDATA[`TOR_CFG_W-1:0]);
        end
    end

    // Pin sampling of every port, whatever its direction
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_in_ff <= '0;
        end else begin
            pin_in_ff <= PIO_IN;
        end
    end

    // Ready trackers; frame rearms when its timing run ends
    tor_trig_ready u_acq_rdy (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(TRIG_EVT.acq),
        .rearm(ACQ_REARM),
        .ready(ready.acq),
        .accept(accept.acq)
    );
    tor_trig_ready u_frame_rdy (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(TRIG_EVT.frame),
        .rearm(frame_rearm),
        .ready(ready.frame),
        .accept(accept.frame)
    );
    tor_trig_ready u_eoe_rdy (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(TRIG_EVT.eoe),
        .rearm(EOE_REARM),
        .ready(ready.eoe),
        .accept(accept.eoe)
    );
    assign TRIG_ACCEPT = accept;
    assign frame_trig_ready_out = ready.frame;

    // Fixed-length trigger pulses on accepted events and processing ticks
    tor_pulse_stretch #(.CYC(TRIG_CYC)) u_acq_pls (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(accept.acq),
        .pulse(trig_pulse.acq)
    );
    tor_pulse_stretch #(.CYC(TRIG_CYC)) u_frame_pls (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(accept.frame),
        .pulse(trig_pulse.frame)
    );
    tor_pulse_stretch #(.CYC(TRIG_CYC)) u_eoe_pls (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(accept.eoe),
        .pulse(trig_pulse.eoe)
    );
    tor_pulse_stretch #(.CYC(TRIG_CYC)) u_enc_pls (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(ENC_TICK),
        .pulse(enc_pulse)
    );
    tor_pulse_stretch #(.CYC(TRIG_CYC)) u_pll_pls (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .evt(PLL_TICK),
        .pulse(pll_pulse)
    );
    assign frame_trig_pulse_out = trig_pulse.frame;

    // Microsecond prescaler, rephased on every accepted frame event
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_ff <= '0;
        end else if (accept.frame || us_tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end
    assign us_tick = (pre_ff == PW'(US_CYC - 1));

    // Run ends once both strobe fall and exposure end are passed
    assign expo_end = {1'b0, expo_delay_ff} + {1'b0, expo_time_ff};
    assign run_end = (expo_end > {1'b0, strobe_fall_delay_ff}) ? expo_end
        : {1'b0, strobe_fall_delay_ff};
    assign frame_rearm = run_ff && (us_cnt_ff >= run_end);

    // Microsecond counter restarted by each accepted frame event
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            us_cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (accept.frame) begin
            us_cnt_ff <= '0;
            run_ff <= 1'b1;
        end else if (frame_rearm) begin
            run_ff <= 1'b0;
        end else if (run_ff && us_tick) begin
            us_cnt_ff <= us_cnt_ff + 1'b1;
        end
    end

    // Strobe window from its own rise and fall delays; lags one cycle
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strobe_ff <= 1'b0;
        end else begin
            strobe_ff <= run_ff && (us_cnt_ff >= {1'b0, strobe_rise_delay_ff})
                && (us_cnt_ff < {1'b0, strobe_fall_delay_ff});
        end
    end

    // Exposure window, independent delay so the strobe may lead it
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            expo_ff <= 1'b0;
        end else begin
            expo_ff <= run_ff && (us_cnt_ff >= {1'b0, expo_delay_ff})
                && (us_cnt_ff < expo_end);
        end
    end

    // Per-port source mux, inversion and direction
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        logic lvl;

        always_comb begin
            lvl = 1'b0;
            if (cfg_ff[p].extra_source_enable) begin
                lvl = EXTRA_SRC[cfg_ff[p].extra_source_index];
            end else begin
                unique case (cfg_ff[p].src)
                    TOR_SRC_MANUAL: lvl = cfg_ff[p].manual_val;
                    TOR_SRC_EXPOSURE: lvl = expo_ff;
                    TOR_SRC_STROBE: lvl = strobe_ff;
                    TOR_SRC_ACQ_TRIG: lvl = trig_pulse.acq;
                    TOR_SRC_FRAME_TRIG: lvl = frame_trig_pulse_out;
                    TOR_SRC_EOE_TRIG: lvl = trig_pulse.eoe;
                    TOR_SRC_ACQ_READY: lvl = ready.acq;
                    TOR_SRC_FRAME_READY: lvl = frame_trig_ready_out;
                    TOR_SRC_EOE_READY: lvl = ready.eoe;
                    TOR_SRC_ENC_TRIG: lvl = enc_pulse;
                    TOR_SRC_PLL_TRIG: lvl = pll_pulse;
                    default: lvl = 1'b0; // Illegal code, hold low
                endcase
            end
        end

        // Registered pin so data leaves from a flop
        always_ff @(posedge REF_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                pin_out_ff[p] <= 1'b0;
            end else begin
                pin_out_ff[p] <= lvl ^ cfg_ff[p].invert;
            end
        end

        assign PIO_OE[p] = cfg_ff[p].dir_out;
    end

    assign PIO_OUT = pin_out_ff;
endmodule

// ==== verification/tor_pin_partner.sv ====
// Purpose: Far-side pin model: lights or instruments sharing the port pins.
// Assumes: No pull resistors on the pins.
// Notes: A pin nobody drives wanders every cycle instead of holding its last level.
`timescale 1ns/100ps
module tor_pin_partner #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic [N-1:0] pio_out,
    input wire logic [N-1:0] pio_oe,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    output logic [N-1:0] pio_in
);
    logic [N-1:0] wander_ff = '0;

    // Floating level changes each cycle so a stale value never looks valid
    always_ff @(posedge clk) begin
        wander_ff <= ~wander_ff;
    end

    // Wire level: camera drive first, then the far device, else floating
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pio_in[i] = pio_oe[i] ? pio_out[i] : (ext_en[i] ? ext_val[i] : wander_ff[i]);
        end
    end
endmodule

// ==== verification/tor_top_sva.sv ====
// Purpose: Port-level temporal checks of the output router.
// Assumes: Zero-wait APB, four ports at 0x10..0x1C, status at 0x40.
// Notes: Bound to every tor_top instance.
`timescale 1ns/100ps
module tor_top_sva
import tor_pkg::*;
#(
    parameter int NPORTS = 4
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire tor_pkg::tor_evt_s TRIG_EVT,
    input wire tor_pkg::tor_evt_s TRIG_ACCEPT,
    input wire logic ACQ_REARM,
    input wire logic EOE_REARM,
    input wire logic [NPORTS-1:0] PIO_IN,
    input wire logic [NPORTS-1:0] PIO_OUT,
    input wire logic [NPORTS-1:0] PIO_OE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    // Bus phases and trigger acceptance sequences used by several checks
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    sequence s_status_setup;
        PSEL && !PENABLE && !PWRITE && PADDR == 8'h40;
    endsequence
    sequence s_acq_taken;
        TRIG_ACCEPT.acq ##1 !ACQ_REARM;
    endsequence
    sequence s_eoe_taken;
        TRIG_ACCEPT.eoe ##1 !EOE_REARM;
    endsequence

    a_accept_subset: assert property ((TRIG_ACCEPT & ~TRIG_EVT) == 3'h0)
        else $error("accept without an event");
    a_accept_twice: assert property (|TRIG_ACCEPT
        |=> (TRIG_ACCEPT & $past(TRIG_ACCEPT)) == 3'h0)
        else $error("accepted twice in a row");
    a_acq_refuse: assert property (s_acq_taken |=> !TRIG_ACCEPT.acq)
        else $error("acq event taken while not ready");
    a_eoe_refuse: assert property (s_eoe_taken |=> !TRIG_ACCEPT.eoe)
        else $error("eoe event taken while not ready");
    a_zero_wait: assert property (s_access |-> PREADY)
        else $error("wait state inserted");
    a_unmapped_err: assert property (PSEL && PENABLE && PADDR >= 8'h20 && PADDR != 8'h40
        |-> PSLVERR)
        else $error("unmapped access not refused");
    a_status_ok: assert property (PSEL && PENABLE && PADDR == 8'h40
        |-> !PSLVERR && PRDATA[31:12] == 20'h0)
        else $error("status access faulted");
    a_oe_direction: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'h10
        |=> PIO_OE[0] == $past(PWDATA[5]))
        else $error("direction not applied");
    a_manual_level: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'h10
        && PWDATA[7:0] == 8'h60 |-> ##2 PIO_OUT[0])
        else $error("manual level not driven");
    a_status_pins: assert property (s_status_setup ##1 s_access
        |-> PRDATA[11:8] == $past(PIO_IN, 2))
        else $error("pin level not reported");
endmodule

bind tor_top tor_top_sva #(.NPORTS(NPORTS)) u_sva (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TRIG_EVT(TRIG_EVT), .TRIG_ACCEPT(TRIG_ACCEPT), .ACQ_REARM(ACQ_REARM),
    .EOE_REARM(EOE_REARM), .PIO_IN(PIO_IN), .PIO_OUT(PIO_OUT), .PIO_OE(PIO_OE));

// ==== verification/tor_top_tb.sv ====
// Purpose: Self-checking bench of the output router over APB and pins.
// Assumes: Short microsecond and trigger counts for run time.
// Notes: Reads note their expectation in a queue; a monitor compares on completion.
`timescale 1ns/100ps
`define TOR_CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
    end \
end
module tor_top_tb;
    import tor_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} tor_note_s;
    localparam int US = 10;
    localparam int TRG = 20;
    logic ref_clk = 1'b0;
    logic arst_n, psel, penable, pwrite, pready, pslverr, acq_rearm, eoe_rearm, enc_tick, pll_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] rnd = 32'hC3CE0F01;
    logic [15:0] extra_src;
    logic [3:0] pio_in, pio_out, pio_oe, ext_en, ext_val;
    logic [31:0] e;
    tor_evt_s trig_evt, trig_accept;
    tor_note_s notes[$];
    tor_note_s n;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int t0;

    tor_top #(.US_CYC(US), .TRIG_CYC(TRG)) u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TRIG_EVT(trig_evt),
        .ACQ_REARM(acq_rearm), .EOE_REARM(eoe_rearm), .ENC_TICK(enc_tick), .PLL_TICK(pll_tick),
        .EXTRA_SRC(extra_src), .TRIG_ACCEPT(trig_accept), .PIO_IN(pio_in), .PIO_OUT(pio_out),
        .PIO_OE(pio_oe));
    tor_pin_partner #(.N(4)) u_pins (.clk(ref_clk), .pio_out(pio_out), .pio_oe(pio_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pio_in(pio_in));

    // Clock and cycle count
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; a read leaves its expectation in the queue
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] m);
        int k;
        k = 0;
        if (!wr) notes.push_back('{d, m, (a >= 8'h20 && a != 8'h40)});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : 32'h0;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        if (k == 20) begin
            failures++;
            $display("Error at %0t: no ready from the slave", $time);
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Event pulse; acceptance shows in the same cycle
    task automatic pulse_evt(input logic [2:0] v, input logic [2:0] acc);
        trig_evt <= v;
        #1;
        `TOR_CHK(trig_accept, acc)
        @(posedge ref_clk);
        trig_evt <= 3'h0;
        enc_tick <= 1'b0;
        pll_tick <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Completed reads are matched with the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                failures++;
                $display("Error at %0t: read without a note", $time);
            end else begin
                n = notes.pop_front();
                `TOR_CHK(prdata & n.m, n.d & n.m)
                `TOR_CHK(pslverr, n.e)
            end
        end
    end

    initial begin
        {arst_n, psel, penable, pwrite, acq_rearm, eoe_rearm, enc_tick, pll_tick} = 8'h00;
        {paddr, pwdata, extra_src, trig_evt} = '0;
        ext_en = 4'hF;
        ext_val = 4'hA;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        // Reset state, unmapped place
        for (int a = 0; a < 32; a += 4) xfer(0, a[7:0], 32'h0, 32'hFFFEFFFF);
        xfer(0, 8'h40, 32'h00000A07, 32'hFFFFFFFF);
        xfer(1, 8'h24, 32'hFFFFFFFF, 0);
        xfer(0, 8'h20, 32'h0, 32'hFFFFFFFF);
        // Random delay and port settings read back
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            e = (i < 4) ? (rnd & 32'hFFFF) : (rnd & 32'hFFF);
            xfer(1, 8'(i * 4), rnd, 0);
            xfer(0, 8'(i * 4), e, 32'hFFFEFFFF);
            if (i >= 4) xfer(1, 8'(i * 4), 32'h0, 0);
        end
        // Manual level, inversion and direction on every port
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 4; c++) begin
                xfer(1, 8'(16 + 4 * p), {25'h0, c[1], 1'b1, c[0], 4'h0}, 0);
                repeat (3) @(posedge ref_clk);
                xfer(0, 8'h40, 32'(c[1] ^ c[0]) << (8 + p), 32'h100 << p);
            end
            xfer(1, 8'(16 + 4 * p), 32'h0, 0);
            xfer(0, 8'h40, 32'hA00, 32'h100 << p);
        end
        // Extra source by index
        rnd = lfsr(rnd);
        extra_src <= rnd[15:0];
        xfer(1, 8'h18, 32'h5A0, 0);
        // Pin flop and pin sampler lag two edges behind the new setting
        repeat (3) @(posedge ref_clk);
        xfer(0, 8'h40, 32'(rnd[5]) << 10, 32'h400);
        // Trigger pulses, ready level, refusal
        xfer(1, 8'h10, 32'h23, 0);
        xfer(1, 8'h14, 32'h26, 0);
        xfer(1, 8'h18, 32'h29, 0);
        xfer(1, 8'h1C, 32'h2A, 0);
        enc_tick <= 1'b1;
        pll_tick <= 1'b1;
        pulse_evt(3'b001, 3'b001);
        pulse_evt(3'b001, 3'b000);
        xfer(0, 8'h40, 32'hD00, 32'hF01);
        repeat (TRG + 6) @(posedge ref_clk);
        xfer(0, 8'h40, 32'h0, 32'hF01);
        acq_rearm <= 1'b1;
        @(posedge ref_clk);
        acq_rearm <= 1'b0;
        repeat (3) @(posedge ref_clk);
        xfer(0, 8'h40, 32'h201, 32'h201);
        acq_rearm <= 1'b1;
        trig_evt <= 3'b101;
        @(posedge ref_clk);
        acq_rearm <= 1'b0;
        trig_evt <= 3'h0;
        @(posedge ref_clk);
        xfer(0, 8'h40, 32'h0, 32'h5);
        {acq_rearm, eoe_rearm} <= 2'b11;
        @(posedge ref_clk);
        {acq_rearm, eoe_rearm} <= 2'b00;
        // Frame run: strobe 2..5 us, exposure 3..7 us
        xfer(1, 8'h00, 32'h2, 0);
        xfer(1, 8'h04, 32'h5, 0);
        xfer(1, 8'h08, 32'h3, 0);
        xfer(1, 8'h0C, 32'h4, 0);
        xfer(1, 8'h10, 32'h22, 0);
        xfer(1, 8'h14, 32'h21, 0);
        t0 = cyc;
        pulse_evt(3'b010, 3'b010);
        for (int k = 0; k < 9; k++) begin
            if (k == 1) pulse_evt(3'b010, 3'b000);
            while (cyc < t0 + US * k + 4) @(posedge ref_clk);
            e = ((k >= 2 && k < 5) ? 32'h110 : 0) | ((k >= 3 && k < 7) ? 32'h208 : 0);
            xfer(0, 8'h40, e | ((k >= 7) ? 32'h2 : 0), 32'h31A);
        end
        repeat (4) @(posedge ref_clk);
        close_out();
    end
endmodule
